// file: verilog/pd_alert_pkg.sv
// Holds offsets, field positions, reset values and the event carrier
// for the port alert flag block.
// Assumes a byte-wide register port on the single system clock.
package pd_alert_pkg;

    // Register offsets
    localparam logic [7:0] OFS_FLAGS_LOW  = 8'h10;
    localparam logic [7:0] OFS_FLAGS_HIGH = 8'h11;
    localparam logic [7:0] OFS_ENABLE_LOW = 8'h12;

    // Values after reset
    localparam logic [7:0] RST_FLAGS_LOW  = 8'h00;
    localparam logic [7:0] RST_FLAGS_HIGH = 8'h00;
    localparam logic [7:0] RST_ENABLE_LOW = 8'hFF;

    // Implemented bits of the high flag byte; 6:4 read zero
    localparam logic [7:0] HIGH_IMPL_MASK = 8'h8F;

    // Low byte field positions
    localparam int BIT_BUS_VOLT_HIGH = 7;
    localparam int BIT_TX_DONE_OK    = 6;
    localparam int BIT_TX_ABANDONED  = 5;
    localparam int BIT_TX_NO_ACK     = 4;
    localparam int BIT_RX_HARD_RESET = 3;
    localparam int BIT_RX_MSG        = 2;
    localparam int BIT_POWER_CHANGE  = 1;
    localparam int BIT_CONFIG_CHAN   = 0;

    // High byte field positions
    localparam int BIT_VENDOR_SUMMARY = 7;
    localparam int BIT_SINK_DISCONN   = 3;
    localparam int BIT_RX_OVERFLOW    = 2;
    localparam int BIT_FAULT          = 1;
    localparam int BIT_BUS_VOLT_LOW   = 0;

    // One-cycle event pulses from the surrounding port logic
    typedef struct packed {
        logic busVoltHighAlarm;
        logic txPathReset;
        logic txDoneOk;
        logic txAbandoned;
        logic txNoAck;
        logic rxHardReset;
        logic rxMsgArrived;
        logic rxLenZero;
        logic powerChangeFlag;
        logic configChannelChange;
        logic sinkDisconnectFlag;
        logic rxOverflowFlag;
        logic faultEvent;
        logic busVoltLowAlarm;
    } events_t;

endpackage : pd_alert_pkg

// file: verilog/pd_port_alert_interrupt.sv
// Holds the alert flag bytes, the low enable byte and the active-low
// interrupt line of a power delivery port controller.
// Assumes event pulses and register strobes come from logic on ref_clk.
`timescale 1ns/1ps

// Operation
// - Enabled set flag drives interrupt line low
// - Line stays low until flags cleared or, for low flags, their enables cleared
// - Line releases when nothing set and enabled
// - Low bit 7 sets on high voltage alarm
// - Low bit 6 sets on reset or ack
// - Low bit 5 sets on reset or abandon
// - Low bit 4 sets on missing ack
// - Low bit 3 sets on received hard reset
// - Low bit 2 sets on nonzero-length receive
// - Low bits 1,0 on power, channel change
// - High bit 7 summarises vendor interrupt
// - High bit 3 sets on sink disconnect
// - High bit 2 sets on overflow, acked
// - Overflow condition cleared by receive flag write
// - High bit 1 sets on any fault
// - High bit 0 sets on low voltage alarm
// - Low enable bits gate low flags onto line, reset to ones
// - Flags reset zero, high 6:4 read zero
// - Write one clears, write zero ignored
// - Unmapped reads zero, writes acked, discarded
module pd_port_alert_interrupt (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    // Event sources
    input  wire pd_alert_pkg::events_t events,
    input  wire logic                 vendorIrqPending,
    // Register port
    input  wire logic [7:0]           regAddr,
    input  wire logic                 regWrEn,
    input  wire logic [7:0]           regWrData,
    input  wire logic                 regRdEn,
    output logic      [7:0]           regRdData_q,
    output logic                      regAck_q,
    // Status out
    output logic                      intN_q,
    output logic                      rxOverflowCond_q
);

    logic [7:0] flagsLow_q;
    logic [7:0] flagsLow_d;
    logic [7:0] flagsHigh_q;
    logic [7:0] flagsHigh_d;
    logic [7:0] enableLow_q;
    logic [7:0] setLow;
    logic [7:0] setHigh;
    logic [7:0] clrLow;
    logic [7:0] clrHigh;
    logic       vendorLevel_q;
    logic       vendorRise;
    logic       pendAny;
    logic       wrLow;
    logic       wrEnable;

    ////////////////////////////////////////////////////////////////////////
    // Event decode

    assign vendorRise = vendorIrqPending & ~vendorLevel_q;
    assign wrLow      = regWrEn && (regAddr == pd_alert_pkg::OFS_FLAGS_LOW);
    assign wrEnable   = regWrEn && (regAddr == pd_alert_pkg::OFS_ENABLE_LOW);

    always_comb begin
        setLow = 8'h00;
        setLow[pd_alert_pkg::BIT_BUS_VOLT_HIGH] = events.busVoltHighAlarm;
        setLow[pd_alert_pkg::BIT_TX_DONE_OK] =
            events.txDoneOk | events.txPathReset;
        setLow[pd_alert_pkg::BIT_TX_ABANDONED] =
            events.txAbandoned | events.txPathReset;
        setLow[pd_alert_pkg::BIT_TX_NO_ACK] = events.txNoAck;
        setLow[pd_alert_pkg::BIT_RX_HARD_RESET] = events.rxHardReset;
        setLow[pd_alert_pkg::BIT_RX_MSG] =
            events.rxMsgArrived & ~events.rxLenZero;
        setLow[pd_alert_pkg::BIT_POWER_CHANGE] = events.powerChangeFlag;
        setLow[pd_alert_pkg::BIT_CONFIG_CHAN]  = events.configChannelChange;
    end

    always_comb begin
        setHigh = 8'h00;
        setHigh[pd_alert_pkg::BIT_VENDOR_SUMMARY] = vendorRise;
        setHigh[pd_alert_pkg::BIT_SINK_DISCONN] = events.sinkDisconnectFlag;
        setHigh[pd_alert_pkg::BIT_RX_OVERFLOW] = events.rxOverflowFlag;
        setHigh[pd_alert_pkg::BIT_FAULT] = events.faultEvent;
        setHigh[pd_alert_pkg::BIT_BUS_VOLT_LOW] = events.busVoltLowAlarm;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag registers

    always_comb begin
        clrLow  = wrLow ? regWrData : 8'h00;
        clrHigh = (regWrEn && (regAddr == pd_alert_pkg::OFS_FLAGS_HIGH))
                ? regWrData : 8'h00;
        flagsLow_d  = (flagsLow_q & ~clrLow) | setLow;
        flagsHigh_d = ((flagsHigh_q & ~clrHigh) | setHigh)
                    & pd_alert_pkg::HIGH_IMPL_MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flagsLow_q  <= pd_alert_pkg::RST_FLAGS_LOW;
            flagsHigh_q <= pd_alert_pkg::RST_FLAGS_HIGH;
        end else begin
            flagsLow_q  <= flagsLow_d;
            flagsHigh_q <= flagsHigh_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vendorLevel_q <= 1'b0;
        end else begin
            vendorLevel_q <= vendorIrqPending;
        end
    end

    // cleared only by reset or receive flag write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxOverflowCond_q <= 1'b0;
        end else if (events.rxOverflowFlag) begin
            rxOverflowCond_q <= 1'b1;
        end else if (wrLow && regWrData[pd_alert_pkg::BIT_RX_MSG]) begin
            rxOverflowCond_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable register

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            enableLow_q <= pd_alert_pkg::RST_ENABLE_LOW;
        end else if (wrEnable) begin
            enableLow_q <= regWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt line

    assign pendAny = (|(flagsLow_q & enableLow_q)) | (|flagsHigh_q);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            intN_q <= 1'b1;
        end else begin
            intN_q <= ~pendAny;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port

    // unmapped reads zero, all accesses acked
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regRdData_q <= 8'h00;
            regAck_q    <= 1'b0;
        end else begin
            regAck_q <= regWrEn | regRdEn;
            if (regRdEn) begin
                unique case (regAddr)
                    pd_alert_pkg::OFS_FLAGS_LOW:  regRdData_q <= flagsLow_q;
                    pd_alert_pkg::OFS_FLAGS_HIGH: regRdData_q <= flagsHigh_q;
                    pd_alert_pkg::OFS_ENABLE_LOW: regRdData_q <= enableLow_q;
                    default:                      regRdData_q <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_int_asserts: assert property (@(posedge ref_clk) disable iff (srst)
        pendAny |=> !intN_q) else $error("interrupt not driven low");

    a_int_holds: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(intN_q) |-> !$past(pendAny))
        else $error("interrupt released with flag pending");

    a_int_release: assert property (@(posedge ref_clk) disable iff (srst)
        (!pendAny && !srst) |=> intN_q) else $error("interrupt not released");

    a_volt_high: assert property (@(posedge ref_clk) disable iff (srst)
        events.busVoltHighAlarm |=> flagsLow_q[7])
        else $error("high alarm flag missing");

    a_tx_ok: assert property (@(posedge ref_clk) disable iff (srst)
        (events.txDoneOk || events.txPathReset) |=> flagsLow_q[6])
        else $error("transmit ok flag missing");

    a_tx_abandon: assert property (@(posedge ref_clk) disable iff (srst)
        (events.txAbandoned || events.txPathReset) |=> flagsLow_q[5])
        else $error("transmit abandon flag missing");

    a_tx_noack: assert property (@(posedge ref_clk) disable iff (srst)
        events.txNoAck |=> flagsLow_q[4]) else $error("no ack flag missing");

    a_hard_reset: assert property (@(posedge ref_clk) disable iff (srst)
        events.rxHardReset |=> flagsLow_q[3])
        else $error("hard reset flag missing");

    a_rx_zero_len: assert property (@(posedge ref_clk) disable iff (srst)
        (events.rxMsgArrived && events.rxLenZero && !flagsLow_q[2])
        |=> !flagsLow_q[2]) else $error("zero length set receive flag");

    a_rx_msg_set: assert property (@(posedge ref_clk) disable iff (srst)
        (events.rxMsgArrived && !events.rxLenZero) |=> flagsLow_q[2])
        else $error("receive flag missing");

    a_chan_power: assert property (@(posedge ref_clk) disable iff (srst)
        events.powerChangeFlag |=> flagsLow_q[1])
        else $error("power change flag missing");

    a_chan_cfg: assert property (@(posedge ref_clk) disable iff (srst)
        events.configChannelChange |=> flagsLow_q[0])
        else $error("channel change flag missing");

    a_vendor_sum: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(vendorIrqPending) |=> flagsHigh_q[7])
        else $error("vendor summary missing");

    a_sink_disc: assert property (@(posedge ref_clk) disable iff (srst)
        events.sinkDisconnectFlag |=> flagsHigh_q[3])
        else $error("sink disconnect flag missing");

    a_ovf_flag: assert property (@(posedge ref_clk) disable iff (srst)
        events.rxOverflowFlag |=> (flagsHigh_q[2] && rxOverflowCond_q))
        else $error("overflow flag missing");

    a_ovf_cond: assert property (@(posedge ref_clk) disable iff (srst)
        (rxOverflowCond_q && !(wrLow && regWrData[2])) |=> rxOverflowCond_q)
        else $error("overflow condition lost");

    a_ovf_clear: assert property (@(posedge ref_clk) disable iff (srst)
        (wrLow && regWrData[2] && !events.rxOverflowFlag)
        |=> !rxOverflowCond_q)
        else $error("overflow condition not cleared");

    a_fault_flag: assert property (@(posedge ref_clk) disable iff (srst)
        events.faultEvent |=> flagsHigh_q[1]) else $error("fault flag missing");

    a_volt_low: assert property (@(posedge ref_clk) disable iff (srst)
        events.busVoltLowAlarm |=> flagsHigh_q[0])
        else $error("low alarm flag missing");

    a_enable_gate: assert property (@(posedge ref_clk)
        disable iff (srst)
        (flagsHigh_q == 8'h00 && (flagsLow_q & enableLow_q) == 8'h00)
        |=> intN_q) else $error("disabled event drove interrupt");

    a_reserved_zero: assert property (@(posedge ref_clk)
        disable iff (srst)
        flagsHigh_q[6:4] == 3'b000) else $error("reserved bits set");

    a_reset_vals: assert property (@(posedge ref_clk) srst
        |=> (intN_q && !regAck_q && !rxOverflowCond_q
             && flagsLow_q == pd_alert_pkg::RST_FLAGS_LOW
             && flagsHigh_q == pd_alert_pkg::RST_FLAGS_HIGH
             && enableLow_q == pd_alert_pkg::RST_ENABLE_LOW))
        else $error("reset values wrong");

    a_zero_write: assert property (@(posedge ref_clk) disable iff (srst)
        (wrLow && regWrData == 8'h00)
        |=> flagsLow_q == ($past(flagsLow_q) | $past(setLow)))
        else $error("zero write changed flags");

    a_low_clear: assert property (@(posedge ref_clk) disable iff (srst)
        (wrLow && (regWrData & setLow) == 8'h00)
        |=> (flagsLow_q & $past(regWrData)) == 8'h00)
        else $error("low flag not cleared");

    a_high_clear: assert property (@(posedge ref_clk) disable iff (srst)
        (regWrEn && regAddr == pd_alert_pkg::OFS_FLAGS_HIGH
         && (regWrData & setHigh) == 8'h00)
        |=> (flagsHigh_q & $past(regWrData)) == 8'h00)
        else $error("high flag not cleared");

    a_ack_pulse: assert property (@(posedge ref_clk) disable iff (srst)
        (regWrEn || regRdEn) |=> regAck_q)
        else $error("access not acknowledged");

    a_unmapped_rd: assert property (@(posedge ref_clk)
        disable iff (srst)
        (regRdEn && regAddr > pd_alert_pkg::OFS_ENABLE_LOW)
        |=> (regAck_q && regRdData_q == 8'h00))
        else $error("unmapped read not zero");

    a_set_wins: assert property (@(posedge ref_clk) disable iff (srst)
        (wrLow && (setLow & regWrData) != 8'h00)
        |=> (flagsLow_q & $past(setLow)) == $past(setLow))
        else $error("clear beat set");

endmodule : pd_port_alert_interrupt

// file: tb/pd_host_model.sv
// Host side model: byte register strobes and the vendor source level.
// Assumes the bench calls its tasks; strobes move on falling edges.
`timescale 1ns/1ps
module pd_host_model (
    // Clock
    input  wire logic       ref_clk,
    // Register port
    input  wire logic [7:0] regRdData_q,
    input  wire logic       regAck_q,
    output logic      [7:0] regAddr,
    output logic            regWrEn,
    output logic      [7:0] regWrData,
    output logic            regRdEn,
    // Vendor source
    output logic            vendorIrqPending
);
    logic [7:0] lastRd;
    logic       lastAck;

    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
        vendorIrqPending = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // One-cycle strobe; answer taken one cycle later, then bus scrambled
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = wr;
        regRdEn = !wr;
        @(negedge ref_clk);
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        lastAck = regAck_q;
        lastRd = regRdData_q;
        regAddr = ~a;
        regWrData = ~d;
    endtask : access

    task automatic vendor_clear();
        @(negedge ref_clk);
        vendorIrqPending = 1'b0;
        access(1'b1, pd_alert_pkg::OFS_FLAGS_HIGH, 8'h80);
    endtask : vendor_clear
endmodule : pd_host_model

// file: tb/tb.sv
// Bench for the port alert flag block with a host model on the far side.
// Assumes the design package is compiled first; 40 MHz ref_clk.
`timescale 1ns/1ps
module tb;
    logic                  ref_clk = 1'b0;
    logic                  srst = 1'b1;
    pd_alert_pkg::events_t ev = '0;
    pd_alert_pkg::events_t evz = '0;
    logic [7:0]            regAddr, regWrData, regRdData_q;
    logic                  regWrEn, regRdEn, regAck_q, vendorIrqPending;
    logic                  intN_q, rxOverflowCond_q;
    logic [15:0]           f;
    logic [7:0]            lfsrQ = 8'h59;
    int                    badCount = 0;
    int                    checksDone = 0;

    always #12.5 ref_clk = ~ref_clk;

    pd_port_alert_interrupt dut (.ref_clk(ref_clk), .srst(srst),
        .events(ev), .vendorIrqPending(vendorIrqPending),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData_q(regRdData_q),
        .regAck_q(regAck_q), .intN_q(intN_q),
        .rxOverflowCond_q(rxOverflowCond_q));

    pd_host_model host (.ref_clk(ref_clk), .regRdData_q(regRdData_q),
        .regAck_q(regAck_q), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn),
        .vendorIrqPending(vendorIrqPending));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    function automatic pd_alert_pkg::events_t mk(input int k);
        pd_alert_pkg::events_t e;
        e = '0;
        case (k)
            0: e.configChannelChange = 1'b1;
            1: e.powerChangeFlag = 1'b1;
            2: e.rxMsgArrived = 1'b1;
            3: e.rxHardReset = 1'b1;
            4: e.txNoAck = 1'b1;
            5: e.txAbandoned = 1'b1;
            6: e.txDoneOk = 1'b1;
            7: e.busVoltHighAlarm = 1'b1;
            8: e.busVoltLowAlarm = 1'b1;
            9: e.faultEvent = 1'b1;
            10: e.rxOverflowFlag = 1'b1;
            11: e.sinkDisconnectFlag = 1'b1;
            default: e.txPathReset = 1'b1;
        endcase
        return e;
    endfunction : mk

    function automatic logic [15:0] expf(input int k);
        if (k < 8) return 16'h0001 << k;
        if (k < 12) return 16'h0100 << (k - 8);
        return 16'h0060;
    endfunction : expf

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask : wr

    task automatic rd_flags();
        host.access(1'b0, pd_alert_pkg::OFS_FLAGS_LOW, 8'h00);
        f[7:0] = host.lastRd;
        host.access(1'b0, pd_alert_pkg::OFS_FLAGS_HIGH, 8'h00);
        f[15:8] = host.lastRd;
    endtask : rd_flags

    task automatic pulse(input pd_alert_pkg::events_t e);
        @(negedge ref_clk);
        ev = e;
        @(negedge ref_clk);
        ev = '0;
    endtask : pulse

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    initial begin
        #125000;
        badCount++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge ref_clk);
        srst = 1'b0;
        rd_flags();
        chk(f, 16'h0000);
        chk(intN_q, 1'b1);
        host.access(1'b0, pd_alert_pkg::OFS_ENABLE_LOW, 8'h00);
        chk(host.lastRd, 8'hFF);
        wr(8'h20, 8'hA5);
        chk(host.lastAck, 1'b1);
        host.access(1'b0, 8'h20, 8'h00);
        chk({host.lastAck, host.lastRd}, 16'h0100);
        $display("Test reset done");
        for (int k = 0; k <= 12; k++) begin
            pulse(mk(k));
            chk(intN_q, 1'b1);
            @(negedge ref_clk);
            chk(intN_q, 1'b0);
            rd_flags();
            chk(f, expf(k));
            wr(pd_alert_pkg::OFS_FLAGS_LOW, 8'h00);
            wr(pd_alert_pkg::OFS_FLAGS_HIGH, 8'h00);
            rd_flags();
            chk({f, intN_q}, {expf(k), 1'b0});
            wr(pd_alert_pkg::OFS_FLAGS_LOW, f[7:0] | 8'h70);
            wr(pd_alert_pkg::OFS_FLAGS_HIGH, f[15:8]);
            @(negedge ref_clk);
            chk(intN_q, 1'b1);
        end
        chk(rxOverflowCond_q, 1'b1);
        wr(pd_alert_pkg::OFS_FLAGS_LOW, 8'h04);
        chk(rxOverflowCond_q, 1'b0);
        $display("Test events done");
        evz = mk(2);
        evz.rxLenZero = 1'b1;
        pulse(evz);
        rd_flags();
        chk(f, 16'h0000);
        pulse(mk(3));
        fork
            wr(pd_alert_pkg::OFS_FLAGS_LOW, 8'h08);
            pulse(mk(3));
        join
        rd_flags();
        chk(f, 16'h0008);
        wr(pd_alert_pkg::OFS_FLAGS_LOW, 8'h08);
        $display("Test qualifier and collision done");
        repeat (4) begin
            lfsrQ = lfsr(lfsrQ);
            wr(pd_alert_pkg::OFS_ENABLE_LOW, lfsrQ);
            host.access(1'b0, pd_alert_pkg::OFS_ENABLE_LOW, 8'h00);
            chk(host.lastRd, lfsrQ);
        end
        wr(pd_alert_pkg::OFS_ENABLE_LOW, 8'h00);
        pulse(mk(lfsrQ % 8));
        repeat (2) @(negedge ref_clk);
        chk(intN_q, 1'b1);
        wr(pd_alert_pkg::OFS_ENABLE_LOW, 8'hFF);
        @(negedge ref_clk);
        chk(intN_q, 1'b0);
        wr(pd_alert_pkg::OFS_ENABLE_LOW, 8'h00);
        @(negedge ref_clk);
        chk(intN_q, 1'b1);
        wr(pd_alert_pkg::OFS_FLAGS_LOW, 8'hFF);
        wr(pd_alert_pkg::OFS_ENABLE_LOW, 8'hFF);
        $display("Test enables done");
        @(negedge ref_clk);
        host.vendorIrqPending = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd_flags();
        chk({f, intN_q}, {16'h8000, 1'b0});
        host.vendor_clear();
        rd_flags();
        chk({f, intN_q}, {16'h0000, 1'b1});
        $display("Test vendor summary done");
        report_and_stop();
    end
endmodule : tb
